// ---- hw/cog_pkg.sv ----
// Constants for the six-output clock gating block: register map, field
// positions, reset values and timing counts.
// Assumes a 125 MHz core clock that also serves as the reference clock.
`default_nettype none

package cog_pkg;

  // ----------------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------------
  localparam int NUM_OUTPUTS = 6;
  localparam int REG_ADDR_W  = 3;
  localparam int REG_DATA_W  = 8;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------------
  localparam logic [2:0] REG_RSVD0_IDX      = 3'h0;
  localparam logic [2:0] REG_GATE_A_IDX     = 3'h1;
  localparam logic [2:0] REG_GATE_B_IDX     = 3'h2;
  localparam logic [2:0] REG_IDENT_IDX      = 3'h3;
  localparam logic [2:0] REG_BYTE_COUNT_IDX = 3'h4;
  localparam logic [2:0] REG_STATUS_IDX     = 3'h7;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int OUT0_GATE_BIT_POS = 4;
  localparam int OUT1_GATE_BIT_POS = 2;
  localparam int OUT2_GATE_BIT_POS = 0;
  localparam int OUT3_GATE_BIT_POS = 7;
  localparam int OUT4_GATE_BIT_POS = 6;
  localparam int OUT5_GATE_BIT_POS = 5;
  localparam int STATUS_SETTLED_POS = 7;

  localparam logic [7:0] GATE_A_RESET     = 8'h15;
  localparam logic [7:0] GATE_B_RESET     = 8'he0;
  localparam logic [7:0] BYTE_COUNT_RESET = 8'h06;
  localparam logic [5:0] GATE_BITS_RESET  = 6'h3f;
  // Arbitrary neutral identity value
  localparam logic [7:0] IDENT_DEFAULT    = 8'h5a;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CORE_CLK_HZ         = 125_000_000;
  localparam int SETTLE_TIME_MS      = 5;
  localparam int SETTLE_CYCLES       = (SETTLE_TIME_MS * CORE_CLK_HZ) / 1000;
  localparam int SETTLE_CNT_W        = 20;
  localparam int CORE_PER_OUT_CYCLE  = 2;
  localparam int START_MAX_OUT_CYCLE = 6;

  typedef enum logic {COG_SETTLING, COG_RUNNING} cog_settle_t;

endpackage : cog_pkg

`default_nettype wire

// ---- hw/cog_sync.sv ----
// Multi-stage level synchroniser for a vector of enables.
// Assumes the destination clock is i_core_clk; the first stage feeds only
// the next stage.
`default_nettype none

module cog_sync #(
  parameter int WIDTH  = 6,
  parameter int STAGES = 2
) (
  input  wire logic             i_core_clk, // Core clock
  input  wire logic             i_rst_n,    // Async reset, active low
  input  wire logic             i_clk_en,   // Clock enable
  input  wire logic [WIDTH-1:0] i_d,        // Level to synchronise
  output logic      [WIDTH-1:0] o_q         // Synchronised level
);

  logic [STAGES-1:0][WIDTH-1:0] chain;
  logic [STAGES-1:0][WIDTH-1:0] next_chain;

  if (STAGES < 2 || WIDTH < 1)
  begin : g_bad_params
    $error("cog_sync needs at least two stages and one bit");
  end

  always_comb
  begin
    next_chain = chain;
    if (i_clk_en)
      next_chain = {chain[STAGES-2:0], i_d};
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      chain <= '0;
    else
      chain <= next_chain;
  end

  assign o_q = chain[STAGES-1];

endmodule // cog_sync

`default_nettype wire

// ---- hw/cog_gate.sv ----
// One glitch-free gated clock output.
// Assumes i_want is already synchronous to i_core_clk.
`default_nettype none

module cog_gate (
  input  wire logic i_core_clk, // Core clock
  input  wire logic i_rst_n,    // Async reset, active low
  input  wire logic i_clk_en,   // Clock enable
  input  wire logic i_want,     // Synchronised combined enable
  output logic      o_clk_out,  // Gated output clock, registered
  output logic      o_running   // Gate state, registered
);

  logic out_q;
  logic running;
  logic next_out;
  logic next_running;

  always_comb
  begin
    next_out     = out_q;
    next_running = running;
    if (i_clk_en)
    begin
      // A high phase always completes before a stop
      next_out     = ~out_q & i_want;
      // Gate moves only while the output is low
      next_running = out_q ? running : i_want;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      out_q   <= 1'b0;
      running <= 1'b0;
    end
    else
    begin
      out_q   <= next_out;
      running <= next_running;
    end
  end

  assign o_clk_out = out_q;
  assign o_running = running;

endmodule // cog_gate

`default_nettype wire

// ---- hw/cog_top.sv ----
// Top of the six-output clock gating block: enable bits, register port,
// power-up settling, synchroniser and one gate per output.
// Assumes pins are synchronous to i_core_clk and the far side drives them.
//
// Behaviour
// R01 - Output runs only with pin and bit
// R02 - Either pin low or bit clear stops
// R03 - Far side always drives enable pins
// R04 - Each output stops and starts independently
// R05 - Restart gives only full-width pulses
// R06 - Running within six output cycles of enable
// R07 - Stopped output is parked low
// R08 - Outputs held off until settle time
// R09 - Bits for outputs 0-2 in byte 1
// R10 - Bits for outputs 3-5 in byte 2
// R11 - Control registers reset to defaults
// R12 - Synchronise enables, gate changes when low
`default_nettype none

module cog_top
  import cog_pkg::*;
#(
  parameter int SETTLE_CYCLES_P = SETTLE_CYCLES
) (
  input  wire logic                   i_core_clk,       // Core clock, 125 MHz
  input  wire logic                   i_rst_n,          // Async reset, active low
  input  wire logic                   i_clk_en,         // Freezes state when low
  input  wire logic [NUM_OUTPUTS-1:0] i_out_enable_pin, // Enable pins, active high
  input  wire logic [REG_ADDR_W-1:0]  i_reg_addr,       // Register index
  input  wire logic [REG_DATA_W-1:0]  i_reg_wdata,      // Write data
  input  wire logic                   i_reg_we,         // Write strobe
  input  wire logic                   i_reg_re,         // Read strobe
  output logic      [REG_DATA_W-1:0]  o_reg_rdata,      // Read data, cycle after
  output logic      [NUM_OUTPUTS-1:0] o_buffered_clock_out, // Gated clocks
  output logic      [NUM_OUTPUTS-1:0] o_out_running,    // Gate state per output
  output logic                        o_settled         // Settle time elapsed
);

  // ----------------------------------------------------------------------
  // Elaboration checks and local timing
  // ----------------------------------------------------------------------
  localparam int START_MAX_CORE = START_MAX_OUT_CYCLE * CORE_PER_OUT_CYCLE;

  if (SETTLE_CYCLES_P < 1 || SETTLE_CYCLES_P >= (1 << SETTLE_CNT_W))
  begin : g_bad_settle
    $error("cog_top settle count out of range");
  end

  // ----------------------------------------------------------------------
  // Field mapping
  // ----------------------------------------------------------------------
  function automatic logic [7:0] pack_gate_a(input logic [NUM_OUTPUTS-1:0] bits);
    logic [7:0] b;
    b = 8'h00;
    b[OUT0_GATE_BIT_POS] = bits[0];
    b[OUT1_GATE_BIT_POS] = bits[1];
    b[OUT2_GATE_BIT_POS] = bits[2];
    return b;
  endfunction

  function automatic logic [7:0] pack_gate_b(input logic [NUM_OUTPUTS-1:0] bits);
    logic [7:0] b;
    b = 8'h00;
    b[OUT3_GATE_BIT_POS] = bits[3];
    b[OUT4_GATE_BIT_POS] = bits[4];
    b[OUT5_GATE_BIT_POS] = bits[5];
    return b;
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [NUM_OUTPUTS-1:0] out_gate_bits;
  logic [NUM_OUTPUTS-1:0] next_out_gate_bits;
  logic [7:0]             byte_count;
  logic [7:0]             next_byte_count;
  logic [7:0]             rdata;
  logic [7:0]             next_rdata;
  logic                   settled;

  always_comb
  begin
    next_out_gate_bits = out_gate_bits;
    next_byte_count    = byte_count;
    next_rdata         = 8'h00;
    if (i_clk_en)
    begin
      if (i_reg_we)
      begin
        unique case (i_reg_addr)
          REG_GATE_A_IDX:
          begin
            next_out_gate_bits[0] = i_reg_wdata[OUT0_GATE_BIT_POS]; // [R09]
            next_out_gate_bits[1] = i_reg_wdata[OUT1_GATE_BIT_POS]; // [R09]
            next_out_gate_bits[2] = i_reg_wdata[OUT2_GATE_BIT_POS]; // [R09]
          end
          REG_GATE_B_IDX:
          begin
            next_out_gate_bits[3] = i_reg_wdata[OUT3_GATE_BIT_POS]; // [R10]
            next_out_gate_bits[4] = i_reg_wdata[OUT4_GATE_BIT_POS]; // [R10]
            next_out_gate_bits[5] = i_reg_wdata[OUT5_GATE_BIT_POS]; // [R10]
          end
          REG_BYTE_COUNT_IDX: next_byte_count = i_reg_wdata;
          default: ;
        endcase
      end
      if (i_reg_re)
      begin
        unique case (i_reg_addr)
          REG_GATE_A_IDX:     next_rdata = pack_gate_a(out_gate_bits); // [R09]
          REG_GATE_B_IDX:     next_rdata = pack_gate_b(out_gate_bits); // [R10]
          REG_IDENT_IDX:      next_rdata = IDENT_DEFAULT;
          REG_BYTE_COUNT_IDX: next_rdata = byte_count;
          REG_STATUS_IDX:
          begin
            next_rdata = {2'b00, o_out_running};
            next_rdata[STATUS_SETTLED_POS] = settled;
          end
          // Reserved byte 0 and unmapped indices read zero
          default:            next_rdata = 8'h00;
        endcase
      end
    end
    else
      next_rdata = rdata;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      out_gate_bits <= GATE_BITS_RESET;  // [R11]
      byte_count    <= BYTE_COUNT_RESET; // [R11]
      rdata         <= 8'h00;
    end
    else
    begin
      out_gate_bits <= next_out_gate_bits;
      byte_count    <= next_byte_count;
      rdata         <= next_rdata;
    end
  end

  assign o_reg_rdata = rdata;

  // ----------------------------------------------------------------------
  // Power-up settling
  // ----------------------------------------------------------------------
  cog_settle_t             settle_state;
  cog_settle_t             next_settle_state;
  logic [SETTLE_CNT_W-1:0] settle_cnt;
  logic [SETTLE_CNT_W-1:0] next_settle_cnt;

  always_comb
  begin
    next_settle_state = settle_state;
    next_settle_cnt   = settle_cnt;
    if (i_clk_en)
    begin
      unique case (settle_state)
        COG_SETTLING:
        begin
          next_settle_cnt = settle_cnt + 1'b1;
          if (settle_cnt == SETTLE_CNT_W'(SETTLE_CYCLES_P - 1))
            next_settle_state = COG_RUNNING; // [R08]
        end
        COG_RUNNING: next_settle_cnt = settle_cnt;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      settle_state <= COG_SETTLING;
      settle_cnt   <= '0;
    end
    else
    begin
      settle_state <= next_settle_state;
      settle_cnt   <= next_settle_cnt;
    end
  end

  assign settled   = (settle_state == COG_RUNNING);
  assign o_settled = settled;

  // ----------------------------------------------------------------------
  // Enable combining, synchronising and gating
  // ----------------------------------------------------------------------
  logic [NUM_OUTPUTS-1:0] want_raw;
  logic [NUM_OUTPUTS-1:0] want_sync;

  // Outputs stay silent until settled so consumers never see early clocks
  assign want_raw = i_out_enable_pin & out_gate_bits & {NUM_OUTPUTS{settled}}; // [R01] [R02] [R08]

  // Pins are taken as synchronous, but the extra stages keep the gate clean
  cog_sync #(
    .WIDTH  (NUM_OUTPUTS),
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_clk_en   (i_clk_en),
    .i_d        (want_raw),
    .o_q        (want_sync)
  ); // [R06] [R12]

  for (genvar g = 0; g < NUM_OUTPUTS; g++)
  begin : g_out
    // Each output owns its gate, so others keep running undisturbed
    cog_gate u_gate (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_clk_en   (i_clk_en),
      .i_want     (want_sync[g]),
      .o_clk_out  (o_buffered_clock_out[g]),
      .o_running  (o_out_running[g])
    ); // [R04] [R05] [R07] [R12]

    // --------------------------------------------------------------------
    // Checks per output
    // --------------------------------------------------------------------
    sequence s_want_off;
      !want_raw[g] [*3];
    endsequence

    sequence s_want_on;
      $rose(want_raw[g]) ##1 want_raw[g] [*3];
    endsequence

    property p_needs_both;
      @(posedge i_core_clk) disable iff (!i_rst_n || !i_clk_en)
      $rose(o_buffered_clock_out[g]) |->
        $past(i_out_enable_pin[g], 3) && $past(out_gate_bits[g], 3);
    endproperty
    a_needs_both: assert property (p_needs_both) // [R01]
      else $error("output started without pin and bit");

    property p_either_stops;
      @(posedge i_core_clk) disable iff (!i_rst_n || !i_clk_en)
      s_want_off |=> !o_buffered_clock_out[g];
    endproperty
    a_either_stops: assert property (p_either_stops) // [R02]
      else $error("output still high after enable dropped");

    property p_independent;
      @(posedge i_core_clk) disable iff (!i_rst_n || !i_clk_en)
      $past(want_sync[g]) && $past(i_clk_en) |->
        o_buffered_clock_out[g] != $past(o_buffered_clock_out[g]);
    endproperty
    a_independent: assert property (p_independent) // [R04]
      else $error("enabled output failed to toggle");

    property p_full_pulse;
      @(posedge i_core_clk) disable iff (!i_rst_n || !i_clk_en)
      $rose(o_buffered_clock_out[g]) |=> !o_buffered_clock_out[g] ##1
        (o_buffered_clock_out[g] || !$past(want_sync[g]));
    endproperty
    a_full_pulse: assert property (p_full_pulse) // [R05]
      else $error("short or stretched pulse on output");

    property p_start_latency;
      @(posedge i_core_clk) disable iff (!i_rst_n || !i_clk_en)
      s_want_on |-> ##[0:START_MAX_CORE] o_buffered_clock_out[g];
    endproperty
    a_start_latency: assert property (p_start_latency) // [R06]
      else $error("output did not start in time");

    property p_park_low;
      @(posedge i_core_clk) disable iff (!i_rst_n || !i_clk_en)
      !o_out_running[g] |-> !o_buffered_clock_out[g];
    endproperty
    a_park_low: assert property (p_park_low) // [R07]
      else $error("stopped output not parked low");

    property p_gate_when_low;
      @(posedge i_core_clk) disable iff (!i_rst_n || !i_clk_en)
      $changed(o_out_running[g]) |-> !$past(o_buffered_clock_out[g]);
    endproperty
    a_gate_when_low: assert property (p_gate_when_low) // [R12]
      else $error("gate changed while output high");
  end

  // ----------------------------------------------------------------------
  // Block-level checks
  // ----------------------------------------------------------------------
  property p_silent_settling;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !settled |-> o_buffered_clock_out == '0;
  endproperty
  a_silent_settling: assert property (p_silent_settling) // [R08]
    else $error("clock driven before settle time");

  property p_settle_count;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(settled) |-> $past(settle_cnt) == SETTLE_CNT_W'(SETTLE_CYCLES_P - 1);
  endproperty
  a_settle_count: assert property (p_settle_count) // [R08]
    else $error("settle ended at the wrong count");

  property p_write_a;
    @(posedge i_core_clk) disable iff (!i_rst_n || !i_clk_en)
    i_reg_we && i_reg_addr == REG_GATE_A_IDX |=>
      out_gate_bits[2:0] == {$past(i_reg_wdata[OUT2_GATE_BIT_POS]),
                             $past(i_reg_wdata[OUT1_GATE_BIT_POS]),
                             $past(i_reg_wdata[OUT0_GATE_BIT_POS])};
  endproperty
  a_write_a: assert property (p_write_a) // [R09]
    else $error("byte 1 write did not reach bits");

  property p_write_b;
    @(posedge i_core_clk) disable iff (!i_rst_n || !i_clk_en)
    i_reg_we && i_reg_addr == REG_GATE_B_IDX |=>
      out_gate_bits[5:3] == {$past(i_reg_wdata[OUT5_GATE_BIT_POS]),
                             $past(i_reg_wdata[OUT4_GATE_BIT_POS]),
                             $past(i_reg_wdata[OUT3_GATE_BIT_POS])};
  endproperty
  a_write_b: assert property (p_write_b) // [R10]
    else $error("byte 2 write did not reach bits");

  property p_read_a;
    @(posedge i_core_clk) disable iff (!i_rst_n || !i_clk_en)
    i_reg_re && i_reg_addr == REG_GATE_A_IDX |=>
      (o_reg_rdata & ~GATE_A_RESET) == 8'h00;
  endproperty
  a_read_a: assert property (p_read_a) // [R09]
    else $error("reserved bits of byte 1 read nonzero");

endmodule // cog_top

`default_nettype wire

// ---- sim/cog_far.sv ----
// Far-side model: board logic that drives the enable pins, and a clock
// receiver that flags any gated clock held high for two core cycles.
// Assumes a running output toggles on every core cycle.
`default_nettype none

module cog_far
  import cog_pkg::*;
(
  input  wire logic                   i_core_clk, // Core clock
  input  wire logic                   i_rst_n,    // Async reset, active low
  input  wire logic [NUM_OUTPUTS-1:0] i_pin_cmd,  // Wanted pin levels
  input  wire logic [NUM_OUTPUTS-1:0] i_clk_in,   // Gated clocks received
  output logic      [NUM_OUTPUTS-1:0] o_pin,      // Enable pins, always driven
  output logic      [NUM_OUTPUTS-1:0] o_stretch   // Sticky: pulse too long
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [NUM_OUTPUTS-1:0] last_clk;

  // Pins are driven from reset on, never left to the weak resistor
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pin     <= '0;
      last_clk  <= '0;
      o_stretch <= '0;
    end
    else
    begin
      o_pin     <= i_pin_cmd;
      last_clk  <= i_clk_in;
      o_stretch <= o_stretch | (last_clk & i_clk_in);
    end
  end
endmodule // cog_far

`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the clock gating block: register port, settle
// time, enable latency, parking and random pin and bit mixes.
// Assumes the far-side model in cog_far and a shortened settle count.
`default_nettype none

module tb;
  import cog_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SETTLE_SIM = 8;

  logic                   clk;
  logic                   rst_n;
  logic                   clk_en;
  logic                   we;
  logic                   re;
  logic [REG_ADDR_W-1:0]  addr;
  logic [REG_DATA_W-1:0]  wdata;
  logic [REG_DATA_W-1:0]  rdata;
  logic [REG_DATA_W-1:0]  rd_val;
  logic [NUM_OUTPUTS-1:0] pin_cmd;
  logic [NUM_OUTPUTS-1:0] pins;
  logic [NUM_OUTPUTS-1:0] clk_out;
  logic [NUM_OUTPUTS-1:0] running;
  logic [NUM_OUTPUTS-1:0] stretch;
  logic [NUM_OUTPUTS-1:0] exp_m;
  logic                   settled;
  logic [7:0]             ga;
  logic [7:0]             gb;
  int                     err_count;
  int                     checked;
  int                     n;

  cog_top #(.SETTLE_CYCLES_P(SETTLE_SIM)) dut (
    .i_core_clk           (clk),
    .i_rst_n              (rst_n),
    .i_clk_en             (clk_en),
    .i_out_enable_pin     (pins),
    .i_reg_addr           (addr),
    .i_reg_wdata          (wdata),
    .i_reg_we             (we),
    .i_reg_re             (re),
    .o_reg_rdata          (rdata),
    .o_buffered_clock_out (clk_out),
    .o_out_running        (running),
    .o_settled            (settled)
  );

  cog_far far (
    .i_core_clk (clk),
    .i_rst_n    (rst_n),
    .i_pin_cmd  (pin_cmd),
    .i_clk_in   (clk_out),
    .o_pin      (pins),
    .o_stretch  (stretch)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Which outputs the bits allow, by bit position per output
  function automatic logic [5:0] bit_mask(input logic [7:0] a, input logic [7:0] b);
    return {b[OUT5_GATE_BIT_POS], b[OUT4_GATE_BIT_POS], b[OUT3_GATE_BIT_POS],
            a[OUT2_GATE_BIT_POS], a[OUT1_GATE_BIT_POS], a[OUT0_GATE_BIT_POS]};
  endfunction

  task automatic end_sim();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdata;
  endtask

  // Let gates settle, then every wanted output pulses, every other stays low
  task automatic watch(input logic [5:0] exp);
    logic [5:0] hi;
    hi = '0;
    repeat (14) @(posedge clk);
    repeat (16)
    begin
      @(posedge clk);
      #1 hi = hi | clk_out;
    end
    chk({2'b00, hi}, {2'b00, exp});
    chk({2'b00, running}, {2'b00, exp});
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(rdata, 8'h00);
    chk({1'b0, settled, clk_out}, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < SETTLE_SIM - 1; k++)
    begin
      @(posedge clk);
      #1 chk({1'b0, settled, clk_out}, 8'h00);
    end
    n = 0;
    while (settled !== 1'b1 && n < 2 * SETTLE_SIM)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (settled !== 1'b1)
    begin
      chk({7'h00, settled}, 8'h01);
      end_sim();
    end
    // Settle ends exactly at the programmed count
    chk(8'(n), 8'h01);
    rd(REG_BYTE_COUNT_IDX, rd_val);
    chk(rd_val, BYTE_COUNT_RESET);
    ga = GATE_A_RESET;
    gb = GATE_B_RESET;
    rd(REG_GATE_A_IDX, rd_val);
    chk(rd_val, GATE_A_RESET);
    rd(REG_GATE_B_IDX, rd_val);
    chk(rd_val, GATE_B_RESET);
  endtask

  initial
  begin
    void'($urandom(32'h5f649bfe));
    rst_n     = 1'b0;
    clk_en    = 1'b1;
    we        = 1'b0;
    re        = 1'b0;
    addr      = '0;
    wdata     = '0;
    pin_cmd   = '1;
    err_count = 0;
    checked   = 0;
    do_reset();
    watch(6'h3f);
    rd(REG_IDENT_IDX, rd_val);
    chk(rd_val, IDENT_DEFAULT);
    rd(REG_BYTE_COUNT_IDX, rd_val);
    chk(rd_val, BYTE_COUNT_RESET);
    // --------------------------------------------------------------------
    // Clock enable low freezes all state; frozen in the low phase, as a
    // held high level would be a stretched pulse to the receiver
    // --------------------------------------------------------------------
    @(posedge clk);
    #1 if (clk_out[0] === 1'b0)
      @(posedge clk);
    @(posedge clk);
    clk_en <= 1'b0;
    wr(REG_GATE_A_IDX, 8'h00);
    repeat (4) @(posedge clk);
    #1 chk({1'b0, settled, clk_out}, 8'h40);
    chk({2'b00, running}, 8'h3f);
    @(posedge clk);
    clk_en <= 1'b1;
    rd(REG_GATE_A_IDX, rd_val);
    chk(rd_val, GATE_A_RESET);
    watch(6'h3f);
    // --------------------------------------------------------------------
    // Start one output at a time beside those already running
    // --------------------------------------------------------------------
    pin_cmd <= '0;
    watch(6'h00);
    for (int i = 0; i < NUM_OUTPUTS; i++)
    begin
      @(posedge clk);
      pin_cmd <= pin_cmd | (6'h01 << i);
      n = 0;
      // Bound has one extra cycle for the far-side pin register
      while (clk_out[i] !== 1'b1 && n < 13)
      begin
        @(posedge clk);
        #1 n++;
      end
      if (clk_out[i] !== 1'b1)
      begin
        chk({2'b00, clk_out}, {2'b00, 6'h01 << i});
        end_sim();
      end
      watch(pin_cmd);
    end
    for (int i = 0; i < NUM_OUTPUTS; i++)
    begin
      @(posedge clk);
      pin_cmd <= pin_cmd & ~(6'h01 << i);
      watch(pin_cmd & ~(6'h01 << i));
    end
    // --------------------------------------------------------------------
    // Reserved bits, read-only and unmapped places, then random mixes
    // --------------------------------------------------------------------
    wr(REG_RSVD0_IDX, 8'hff);
    wr(REG_IDENT_IDX, 8'h00);
    rd(REG_RSVD0_IDX, rd_val);
    chk(rd_val, 8'h00);
    rd(REG_IDENT_IDX, rd_val);
    chk(rd_val, IDENT_DEFAULT);
    ga = 8'($urandom);
    wr(REG_BYTE_COUNT_IDX, ga);
    rd(REG_BYTE_COUNT_IDX, rd_val);
    chk(rd_val, ga);
    rd(3'h5, rd_val);
    chk(rd_val, 8'h00);
    for (int it = 0; it < 14; it++)
    begin
      ga = (it == 0) ? 8'hff : (it == 1) ? 8'h00 : 8'($urandom);
      gb = (it == 0) ? 8'hff : (it == 1) ? 8'hff : 8'($urandom);
      wr(REG_GATE_A_IDX, ga);
      wr(REG_GATE_B_IDX, gb);
      pin_cmd <= (it < 2) ? 6'h3f : 6'($urandom);
      @(posedge clk);
      exp_m = bit_mask(ga, gb) & pin_cmd;
      watch(exp_m);
      rd(REG_GATE_A_IDX, rd_val);
      chk(rd_val, ga & GATE_A_RESET);
      rd(REG_GATE_B_IDX, rd_val);
      chk(rd_val, gb & GATE_B_RESET);
      rd(REG_STATUS_IDX, rd_val);
      chk(rd_val, {2'b10, exp_m});
    end
    // --------------------------------------------------------------------
    // Reset in mid-run brings the bits back to enabled
    // --------------------------------------------------------------------
    pin_cmd <= '1;
    do_reset();
    watch(6'h3f);
    chk({2'b00, stretch}, 8'h00);
    end_sim();
  end
endmodule // tb

`default_nettype wire
